// ==== inc/srp_pkg.sv ====
// Package of constants and types for the self-refresh power controller.
package srp_pkg;

  localparam int SRP_NCH = 4;
  localparam int SRP_CNT_W = 16;

  // Register byte offsets.
  localparam logic [7:0] SRP_OFF_CTRL = 8'h00;
  localparam logic [7:0] SRP_OFF_IDLE = 8'h04;
  localparam logic [7:0] SRP_OFF_USED = 8'h08;
  localparam logic [7:0] SRP_OFF_STAT = 8'h0c;
  localparam logic [7:0] SRP_OFF_TEMP = 8'h10;
  localparam logic [7:0] SRP_OFF_LINK = 8'h14;

  // Control register fields.
  localparam int SRP_CTRL_IDLE_EN = 0;
  localparam int SRP_CTRL_DLL_EN = 1;
  localparam int SRP_CTRL_PLL_EN = 2;

  // Reset values.
  localparam logic [2:0] SRP_CTRL_RST = 3'h0;
  localparam logic [SRP_CNT_W-1:0] SRP_IDLE_RST = 16'h0100;
  localparam logic [SRP_NCH-1:0] SRP_USED_RST = 4'hf;

  // Link power: bit 0 is L1 support, bit 1 is L0s support.
  localparam logic [1:0] SRP_ASPM_CAP = 2'h1;

  // Three cycles in SRP_ENTER for the DRAM to complete self-refresh entry.
  localparam logic [3:0] SRP_ENTRY_CYC = 4'h2;

  // AXI responses.
  localparam logic [1:0] SRP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRP_RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    SRP_RUN = 6'h01,
    SRP_ENTER = 6'h02,
    SRP_DLL_OFF = 6'h04,
    SRP_IN_SR = 6'h08,
    SRP_PLL_WAIT = 6'h10,
    SRP_EXIT = 6'h20
  } srp_state_t;

  typedef struct packed {
    logic idle_en;
    logic dll_en;
    logic pll_en;
    logic [SRP_CNT_W-1:0] idle_thr;
  } srp_cfg_t;

  typedef struct packed {
    logic cke;
    logic nop;
    logic dll_off;
    logic pll_off_req;
    logic in_sr;
    logic hold;
  } srp_chout_t;

endpackage

// ==== verilog/srp_chan.sv ====
// One channel of self-refresh sequencing with its idle counter.
`timescale 1ns/1ps
`default_nettype none
module srp_chan
  import srp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire srp_cfg_t cfg,
  input wire logic used,
  input wire logic pcu_sr_req,
  input wire logic pcu_exit,
  input wire logic pkg_active,
  input wire logic access,
  input wire logic pending,
  input wire logic pll_ready,
  output srp_chout_t ch
);
  srp_state_t state_ff;
  srp_state_t nxt_state;
  logic [SRP_CNT_W-1:0] idle_ff;
  logic [3:0] wait_ff;
  logic idle_hit;

  assign idle_hit = cfg.idle_en && pkg_active && idle_ff >= cfg.idle_thr;

  always_ff @(posedge aclk) begin
    if (!aresetn || access || pending || state_ff != SRP_RUN) begin
      idle_ff <= '0;
    end else if (!idle_hit) begin
      idle_ff <= idle_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SRP_RUN: begin
        if (used && (pcu_sr_req || idle_hit) && !access && !pending) begin
          nxt_state = SRP_ENTER;
        end
      end
      SRP_ENTER: begin
        if (wait_ff == SRP_ENTRY_CYC) begin
          nxt_state = cfg.dll_en ? SRP_DLL_OFF : SRP_IN_SR;
        end
      end
      SRP_DLL_OFF: nxt_state = SRP_IN_SR;
      SRP_IN_SR: begin
        if (pcu_exit || access) begin
          nxt_state = cfg.pll_en ? SRP_PLL_WAIT : SRP_EXIT;
        end
      end
      SRP_PLL_WAIT: begin
        if (pll_ready) begin
          nxt_state = SRP_EXIT;
        end
      end
      SRP_EXIT: nxt_state = SRP_RUN;
      default: nxt_state = SRP_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SRP_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != SRP_ENTER) begin
      wait_ff <= '0;
    end else begin
      wait_ff <= wait_ff + 1'b1;
    end
  end

  // The DLL stays off until the channel moves to SRP_EXIT.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch <= '0;
      ch.cke <= 1'b1;
    end else begin
      ch.cke <= !(nxt_state inside {SRP_ENTER, SRP_DLL_OFF, SRP_IN_SR,
                                   SRP_PLL_WAIT});
      ch.nop <= nxt_state != SRP_RUN;
      ch.dll_off <= (nxt_state inside {SRP_DLL_OFF, SRP_IN_SR,
                                      SRP_PLL_WAIT})
                    && cfg.dll_en;
      ch.pll_off_req <= nxt_state == SRP_IN_SR && cfg.pll_en;
      ch.in_sr <= nxt_state inside {SRP_DLL_OFF, SRP_IN_SR, SRP_PLL_WAIT};
      ch.hold <= nxt_state != SRP_RUN;
    end
  end

  dll_after_sr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ch.dll_off) |-> !ch.cke && $past(!ch.cke, 2))
    else $error("DLL shut down before self refresh completed");
  pll_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_PLL_WAIT && !pll_ready |=> ch.hold)
    else $error("Resumed before PLL ready");
  idle_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    access |=> idle_ff == '0)
    else $error("Idle counter not cleared on access");
  idle_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_RUN && !access && !pending && !idle_hit
    |=> idle_ff == $past(idle_ff) + 1'b1)
    else $error("Idle counter did not advance");
  no_idle_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_RUN && !cfg.idle_en && !pcu_sr_req
    |=> state_ff == SRP_RUN)
    else $error("Idle entry while disabled");
  pcu_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_RUN && used && pcu_sr_req && !access && !pending
    |=> state_ff == SRP_ENTER ##1 !ch.cke && ch.nop)
    else $error("Power control request not carried out");
  exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_IN_SR && pcu_exit |=> state_ff != SRP_IN_SR)
    else $error("Exit message ignored");
  hold_sr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == SRP_IN_SR |=> ch.hold)
    else $error("Transaction not held in self refresh");
  sr_entry_c: cover property (@(posedge aclk) state_ff == SRP_IN_SR);
  pll_wake_c: cover property (@(posedge aclk)
    state_ff == SRP_PLL_WAIT ##1 state_ff == SRP_EXIT);
  dll_c: cover property (@(posedge aclk) state_ff == SRP_DLL_OFF);
endmodule
`default_nettype wire

// ==== verilog/srp_ctrl.sv ====
// Top of the multi-channel self-refresh power controller with AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// - A power control unit request puts a channel's DRAMs into self refresh.
// - Each channel enters and leaves self refresh on its own.
// - In the active package state a channel may self-refresh on its own.
// - Idle-driven entry is either disabled or fires at an idle threshold.
// - The idle counter clears on any access and stays clear while busy.
// - When drained the counter counts up and entry happens at threshold.
// - Self refresh ends on an exit message or an incoming transaction.
// - Configuration bits choose whether entry also stops the DLL and PLL.
// - The master DLL is shut down only after self refresh is complete.
// - After PLL wake-up the channel waits for PLL ready before resuming.
// - Output drivers of unused signals and channels are tristated.
// - Input receivers of unused signals are disabled and inputs gated.
// - Link power management advertises and enters only L1, never L0s.
// - Sensor values 1 to 0x80 are reported as a negative offset below throttle.
// - Power-down drops clock enable with a NOP and raises it with a NOP.
module srp_ctrl
  import srp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SRP_NCH-1:0] pcu_sr_req,
  input wire logic [SRP_NCH-1:0] pcu_exit,
  input wire logic pkg_active,
  input wire logic [SRP_NCH-1:0] mem_access,
  input wire logic [SRP_NCH-1:0] mem_pending,
  input wire logic [SRP_NCH-1:0] pll_ready,
  input wire logic [7:0] die_temp_sensor,
  input wire logic [SRP_NCH-1:0] dq_in,
  output logic [SRP_NCH-1:0] dq_out,
  output logic [SRP_NCH-1:0] dq_oe,
  output logic [SRP_NCH-1:0] rx_en,
  output logic [SRP_NCH-1:0] dq_gated,
  output logic [SRP_NCH-1:0] cke,
  output logic [SRP_NCH-1:0] cmd_nop,
  output logic [SRP_NCH-1:0] dll_off,
  output logic [SRP_NCH-1:0] pll_off_req,
  output logic [SRP_NCH-1:0] sr_active,
  output logic [SRP_NCH-1:0] txn_hold,
  output logic aspm_l1_en,
  output logic aspm_l0s_en,
  output logic [7:0] temp_offset
);
  logic [2:0] ctrl_ff;
  logic [SRP_CNT_W-1:0] idle_thr_ff;
  logic [SRP_NCH-1:0] used_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic [31:0] nxt_rdata;
  logic rd_ok;
  srp_cfg_t cfg;
  srp_chout_t ch [SRP_NCH];

  assign cfg.idle_en = ctrl_ff[SRP_CTRL_IDLE_EN];
  assign cfg.dll_en = ctrl_ff[SRP_CTRL_DLL_EN];
  assign cfg.pll_en = ctrl_ff[SRP_CTRL_PLL_EN];
  assign cfg.idle_thr = idle_thr_ff;

  // Write address and data are latched independently in either order.
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= SRP_CTRL_RST;
      idle_thr_ff <= SRP_IDLE_RST;
      used_ff <= SRP_USED_RST;
    end else if (wr_go) begin
      case (awaddr_ff)
        SRP_OFF_CTRL: begin
          if (wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[2:0];
          end
        end
        SRP_OFF_IDLE: begin
          if (wstrb_ff[0]) begin
            idle_thr_ff[7:0] <= wdata_ff[7:0];
          end
          if (wstrb_ff[1]) begin
            idle_thr_ff[15:8] <= wdata_ff[15:8];
          end
        end
        SRP_OFF_USED: begin
          if (wstrb_ff[0]) begin
            used_ff <= wdata_ff[SRP_NCH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SRP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_ff == SRP_OFF_CTRL || awaddr_ff == SRP_OFF_IDLE
                      || awaddr_ff == SRP_OFF_USED) ? SRP_RESP_OKAY
                                                     : SRP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    nxt_rdata = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      SRP_OFF_CTRL: nxt_rdata[2:0] = ctrl_ff;
      SRP_OFF_IDLE: nxt_rdata[SRP_CNT_W-1:0] = idle_thr_ff;
      SRP_OFF_USED: nxt_rdata[SRP_NCH-1:0] = used_ff;
      SRP_OFF_STAT: nxt_rdata[2*SRP_NCH-1:0] = {dll_off, sr_active};
      SRP_OFF_TEMP: nxt_rdata[7:0] = temp_offset;
      SRP_OFF_LINK: nxt_rdata[1:0] = {aspm_l0s_en, aspm_l1_en};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SRP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= rd_ok ? SRP_RESP_OKAY : SRP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // One sequencer per channel keeps the channels independent.
  for (genvar i = 0; i < SRP_NCH; i++) begin : g_ch
    srp_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg),
      .used(used_ff[i]),
      .pcu_sr_req(pcu_sr_req[i]),
      .pcu_exit(pcu_exit[i]),
      .pkg_active(pkg_active),
      .access(mem_access[i]),
      .pending(mem_pending[i]),
      .pll_ready(pll_ready[i]),
      .ch(ch[i])
    );
    assign cke[i] = ch[i].cke;
    assign cmd_nop[i] = ch[i].nop;
    assign dll_off[i] = ch[i].dll_off;
    assign pll_off_req[i] = ch[i].pll_off_req;
    assign sr_active[i] = ch[i].in_sr;
    assign txn_hold[i] = ch[i].hold;
  end

  // Unused channels and channels in self refresh have no live data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_oe <= '0;
      rx_en <= '0;
      dq_gated <= '0;
      dq_out <= '0;
    end else begin
      dq_oe <= used_ff & ~sr_active;
      rx_en <= used_ff & ~sr_active;
      dq_gated <= dq_in & used_ff & ~sr_active;
      dq_out <= '0;
    end
  end

  // The sensor gives a distance below throttle; it is reported negated.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_offset <= '0;
      aspm_l1_en <= 1'b0;
      aspm_l0s_en <= 1'b0;
    end else begin
      temp_offset <= 8'(-die_temp_sensor);
      aspm_l1_en <= SRP_ASPM_CAP[0];
      aspm_l0s_en <= 1'b0;
    end
  end

  no_l0s_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !aspm_l0s_en)
    else $error("L0s advertised");
  unused_tri_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(used_ff[3]) |=> !dq_oe[3] && !rx_en[3])
    else $error("Unused channel still driven");
  temp_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(die_temp_sensor) != 8'h00 |-> temp_offset[7]
    || $past(die_temp_sensor) > 8'h80)
    else $error("Temperature not negative");
  wr_c: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  rd_c: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ==== tb/srp_partner.sv ====
// Far-side model: PLL handling of the power unit and the memory pads.
`timescale 1ns/1ps
`default_nettype none
module srp_partner
  import srp_pkg::*;
#(
  parameter int WAKE_CYC = 6
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SRP_NCH-1:0] pll_off_req,
  input wire logic [SRP_NCH-1:0] dq_oe,
  input wire logic [SRP_NCH-1:0] dq_out,
  output logic [SRP_NCH-1:0] pll_ready,
  output logic [SRP_NCH-1:0] dq_in
);
  logic [7:0] lock_cnt_ff [SRP_NCH];
  logic [SRP_NCH-1:0] noise_ff;

  // The PLL stops while asked to and needs a lock delay to come back.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < SRP_NCH; i++) begin
      if (!aresetn || pll_off_req[i]) begin
        lock_cnt_ff[i] <= 8'h00;
      end else if (lock_cnt_ff[i] != 8'hff) begin
        lock_cnt_ff[i] <= lock_cnt_ff[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < SRP_NCH; i++) begin
      pll_ready[i] = (lock_cnt_ff[i] >= 8'(WAKE_CYC));
    end
  end

  // A released pad floats, so it shows a pattern that changes each cycle.
  always_ff @(posedge aclk) begin
    noise_ff <= aresetn ? ~noise_ff : 4'h5;
  end

  assign dq_in = (dq_oe & dq_out) | (~dq_oe & noise_ff);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench of the self-refresh power controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
  import srp_pkg::*;
  localparam int WAKE = 6;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } srp_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pkg_active = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, pcu_sr_req = 4'h0, pcu_exit = 4'h0;
  logic [3:0] mem_access = 4'h0, mem_pending = 4'hf;
  logic [7:0] die_temp_sensor = 8'h05;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, aspm_l1_en, aspm_l0s_en;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] temp_offset;
  wire logic [3:0] pll_ready, dq_in, dq_out, dq_oe, rx_en, dq_gated, cke;
  wire logic [3:0] cmd_nop, dll_off, pll_off_req, sr_active, txn_hold;
  int mismatches = 0, num_checks = 0, n;
  logic [31:0] d;
  logic [1:0] r;
  srp_row_t rows [7];

  srp_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pcu_sr_req, .pcu_exit,
    .pkg_active, .mem_access, .mem_pending, .pll_ready, .die_temp_sensor,
    .dq_in, .dq_out, .dq_oe, .rx_en, .dq_gated, .cke, .cmd_nop, .dll_off,
    .pll_off_req, .sr_active, .txn_hold, .aspm_l1_en, .aspm_l0s_en,
    .temp_offset);
  srp_partner #(.WAKE_CYC(WAKE)) u_far (.aclk, .aresetn, .pll_off_req,
    .dq_oe, .dq_out, .pll_ready, .dq_in);

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && s_axi_awready) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Tests take well under a thousand cycles; this margin catches a hang.
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    rows = '{'{SRP_OFF_CTRL, 32'h0, 32'h7, SRP_RESP_OKAY},
      '{SRP_OFF_IDLE, 32'h100, 32'hffff, SRP_RESP_OKAY},
      '{SRP_OFF_USED, 32'hf, 32'hf, SRP_RESP_OKAY},
      '{SRP_OFF_STAT, 32'h0, 32'hff, SRP_RESP_OKAY},
      '{SRP_OFF_TEMP, 32'hfb, 32'hff, SRP_RESP_OKAY},
      '{SRP_OFF_LINK, 32'h1, 32'h3, SRP_RESP_OKAY},
      '{8'h18, 32'h0, 32'h0, SRP_RESP_SLVERR}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("cke_rst", 4'hf, cke)
    `CHK("sr_rst", 4'h0, sr_active)
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK("resp", rows[i].r, r)
      `CHK("rdata", rows[i].d & rows[i].m, d & rows[i].m)
    end
    `CHK("l1", 1'b1, aspm_l1_en)
    `CHK("l0s", 1'b0, aspm_l0s_en)
    `CHK("temp", 8'hfb, temp_offset)
    wr(SRP_OFF_STAT, 32'hf);
    `CHK("ro_wr", SRP_RESP_SLVERR, r)
    $display("test registers done");
    // Requested entry with DLL and PLL shutdown, then exit on a transaction.
    wr(SRP_OFF_CTRL, 32'h6);
    mem_pending <= 4'he;
    pcu_sr_req <= 4'h1;
    do @(posedge aclk); while (cke[0] !== 1'b0);
    `CHK("nop_in", 1'b1, cmd_nop[0])
    `CHK("dll_early", 1'b0, dll_off[0])
    do @(posedge aclk); while (sr_active[0] !== 1'b1);
    cyc(2);
    `CHK("dll_off", 1'b1, dll_off[0])
    `CHK("pll_off", 1'b1, pll_off_req[0])
    `CHK("one_chan", 4'h1, sr_active)
    `CHK("oe_sr", 1'b0, dq_oe[0])
    `CHK("hold_sr", 1'b1, txn_hold[0])
    pcu_sr_req <= 4'h0;
    mem_access <= 4'h1;
    @(posedge aclk);
    mem_access <= 4'h0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (txn_hold[0] !== 1'b0);
    `CHK("pll_rdy", 1'b1, pll_ready[0])
    `CHK("wake_wait", 1'b1, n >= WAKE)
    cyc(2);
    `CHK("cke_back", 1'b1, cke[0])
    $display("test request entry done");
    // Idle entry on channel 1 only, with the counter cleared by an access.
    mem_pending <= 4'hd;
    pkg_active <= 1'b1;
    cyc(20);
    `CHK("idle_off", 4'h0, sr_active)
    mem_access <= 4'h2;
    wr(SRP_OFF_IDLE, 32'h8);
    wr(SRP_OFF_CTRL, 32'h1);
    mem_access <= 4'h0;
    cyc(5);
    mem_access <= 4'h2;
    @(posedge aclk);
    mem_access <= 4'h0;
    cyc(5);
    `CHK("idle_clr", 1'b0, sr_active[1])
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sr_active[1] !== 1'b1);
    `CHK("idle_hit", 1'b1, n <= 16)
    `CHK("idle_one", 4'h2, sr_active)
    wr(SRP_OFF_CTRL, 32'h0);
    pcu_exit <= 4'h2;
    @(posedge aclk);
    pcu_exit <= 4'h0;
    do @(posedge aclk); while (txn_hold[1] !== 1'b0);
    cyc(2);
    `CHK("msg_exit", 4'h0, sr_active)
    $display("test idle entry done");
    // An unused channel is released and its input gated.
    wr(SRP_OFF_USED, 32'h7);
    cyc(3);
    `CHK("oe_used", 4'h7, dq_oe)
    `CHK("rx_used", 4'h7, rx_en)
    `CHK("gate_off", 1'b0, dq_gated[3])
    `CHK("dq_out", 4'h0, dq_out)
    $display("test unused channel done");
    give_verdict();
  end
endmodule
`default_nettype wire
